/* File: hw/atd_device.sv */
// Converter end: self-trim sequencer, power-down handling and 1:2 output demultiplexer.
`timescale 1ns/1ns
`include "atd_defs.svh"

module atd_device
  import atd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Converter core
  input wire logic signed [9:0] conv_value,
  output logic core_sleep,
  output logic core_trim,
  // Link to the receiver
  atd_link_if.dev link
);

  // ==========================================================
  // Conversion to offset binary with clipping

  // Returns {clipped, code}; the core value is two's complement.
  function automatic logic [8:0] to_offset(input logic signed [9:0] v);
    logic [8:0] r;
    r = {1'b0, v[7:0] ^ 8'h80};
    if (v > 10'sd127) begin
      r = {1'b1, 8'hff};
    end else if (v < -10'sd128) begin
      r = {1'b1, 8'h00};
    end
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisers for the receiver's control pins

  logic [2:0] req_s;
  logic [2:0] lp_s;
  logic [2:0] edge_s;
  logic [2:0] dly_s;
  logic req_f;
  logic lp_f;
  logic edge_f;
  logic dly_f;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_s <= 3'h0;
      lp_s <= 3'h0;
      edge_s <= 3'h0;
      dly_s <= 3'h0;
    end else begin
      req_s <= {req_s[1:0], link.selftrim_request};
      lp_s <= {lp_s[1:0], link.low_power_request};
      edge_s <= {edge_s[1:0], link.launch_edge_select};
      dly_s <= {dly_s[1:0], link.selftrim_delay_select};
    end
  end

  // A level is taken once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_f <= 1'b0;
      lp_f <= 1'b0;
      edge_f <= 1'b0;
      dly_f <= 1'b0;
    end else begin
      if (req_s[1] == req_s[2]) req_f <= req_s[2];
      if (lp_s[1] == lp_s[2]) lp_f <= lp_s[2];
      if (edge_s[1] == edge_s[2]) edge_f <= edge_s[2];
      if (dly_s[1] == dly_s[2]) dly_f <= dly_s[2];
    end
  end

  // ==========================================================
  // Request qualifier

  atd_state_e state_q;
  atd_state_e state_d;
  logic req_prev_q;
  logic [3:0] run_cnt_q;
  logic [3:0] run_cnt_d;
  logic low_ok_q;
  logic low_ok_d;
  wire logic asleep = (state_q == ATD_ST_SLEEP);
  wire logic run_same = (req_f == req_prev_q);
  wire logic run_full = (run_cnt_q == `ATD_QUAL_CYCLES);
  wire logic run_tenth = run_same && (run_cnt_q == `ATD_QUAL_CYCLES - 4'd1);
  wire logic trim_trig = req_f && run_tenth && low_ok_q;

  // Count restarts on every change of level and saturates at the qualifying length.
  assign run_cnt_d = asleep ? 4'h0 :
                     !run_same ? 4'h1 :
                     run_full ? run_cnt_q : run_cnt_q + 4'h1;
  // A qualified low phase arms the trigger; the following qualified high fires it.
  assign low_ok_d = asleep ? 1'b0 :
                    trim_trig ? 1'b0 :
                    (!req_f && run_tenth) ? 1'b1 : low_ok_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_prev_q <= 1'b0;
      run_cnt_q <= 4'h0;
      low_ok_q <= 1'b0;
    end else begin
      req_prev_q <= req_f;
      run_cnt_q <= run_cnt_d;
      low_ok_q <= low_ok_d;
    end
  end

  // ==========================================================
  // Trim sequencer

  logic [2:0] boot_cnt_q;
  logic [11:0] delay_cnt_q;
  logic [7:0] trim_cnt_q;
  wire logic boot_done = (boot_cnt_q == `ATD_BOOT_CYCLES);
  wire logic [11:0] delay_lim = dly_f ? `ATD_DELAY_LONG : `ATD_DELAY_SHORT;
  wire logic delay_done = (delay_cnt_q == delay_lim - 12'd1);
  wire logic trim_done = (trim_cnt_q == `ATD_TRIM_CYCLES - 8'd1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ATD_ST_BOOT: begin
        // The boot wait lets the pin straps pass the synchronisers.
        if (boot_done) begin
          state_d = req_f ? ATD_ST_IDLE : ATD_ST_POR_WAIT;
        end
      end
      ATD_ST_POR_WAIT: begin
        if (!lp_f && (delay_done || trim_trig)) begin
          state_d = ATD_ST_TRIM;
        end
      end
      ATD_ST_TRIM: begin
        if (trim_done) begin
          state_d = lp_f ? ATD_ST_SLEEP : ATD_ST_IDLE;
        end
      end
      ATD_ST_IDLE: begin
        if (lp_f) begin
          state_d = ATD_ST_SLEEP;
        end else if (trim_trig) begin
          state_d = ATD_ST_TRIM;
        end
      end
      ATD_ST_SLEEP: begin
        if (!lp_f) begin
          state_d = ATD_ST_IDLE;
        end
      end
      default: state_d = ATD_ST_BOOT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ATD_ST_BOOT;
      boot_cnt_q <= 3'h0;
      delay_cnt_q <= 12'h000;
      trim_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (!boot_done) boot_cnt_q <= boot_cnt_q + 3'h1;
      // The delay counter stands still while power-down is held.
      if (state_q == ATD_ST_POR_WAIT && !lp_f) delay_cnt_q <= delay_cnt_q + 12'h001;
      trim_cnt_q <= (state_q == ATD_ST_TRIM) ? trim_cnt_q + 8'h01 : 8'h00;
    end
  end

  // Waiting for the delay with power-down held counts as powered down.
  wire logic sleep_w = asleep || (state_q == ATD_ST_POR_WAIT && lp_f);

  // ==========================================================
  // Sample divider and 1:2 demultiplexer

  logic [2:0] div_q;
  logic phase_q;
  atd_code_t pend_a_q;
  logic pend_clip_q;
  atd_code_t bus_a_q;
  atd_code_t bus_b_q;
  logic oor_q;
  logic strobe_q;
  logic oe_q;
  logic active_q;
  logic core_sleep_q;
  wire logic tick = (div_q == `ATD_SAMPLE_DIV) && !sleep_w;
  wire logic [8:0] conv = to_offset(conv_value);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      phase_q <= 1'b0;
    end else if (!sleep_w) begin
      div_q <= div_q + 3'h1;
      if (tick) phase_q <= !phase_q;
    end
  end

  // Even samples wait in the holding register; odd samples complete the pair.
  // With no clock the registers simply hold, so the pins keep the last pair.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_a_q <= 8'h80;
      pend_clip_q <= 1'b0;
      bus_a_q <= 8'h80;
      bus_b_q <= 8'h80;
      oor_q <= 1'b0;
      strobe_q <= 1'b0;
    end else if (tick && !phase_q) begin
      pend_a_q <= conv[7:0];
      pend_clip_q <= conv[8];
      strobe_q <= !edge_f;
    end else if (tick) begin
      bus_a_q <= pend_a_q;
      bus_b_q <= conv[7:0];
      oor_q <= pend_clip_q | conv[8];
      strobe_q <= edge_f;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
      active_q <= 1'b0;
      core_sleep_q <= 1'b0;
    end else begin
      // Pins stay released during boot, before the power-down strap is known.
      oe_q <= !sleep_w && (state_q != ATD_ST_BOOT);
      active_q <= (state_d == ATD_ST_TRIM);
      core_sleep_q <= sleep_w;
    end
  end

  // ==========================================================
  // Outputs

  assign link.bus_a = bus_a_q;
  assign link.bus_b = bus_b_q;
  assign link.output_strobe = strobe_q;
  assign link.out_of_range = oor_q;
  assign link.pins_oe = oe_q;
  assign link.selftrim_active = active_q;
  assign core_sleep = core_sleep_q;
  assign core_trim = active_q;

endmodule // atd_device

/* File: shared/atd_defs.svh */
// Constants shared by both ends of the converter link: timing counts, offsets, bit positions.
`ifndef ATD_DEFS_SVH
`define ATD_DEFS_SVH

// ==========================================================
// Timing counts, in cycles of clk (10 MHz)
`define ATD_QUAL_CYCLES 4'd10
`define ATD_BOOT_CYCLES 3'd4
`define ATD_DELAY_SHORT 12'd256
`define ATD_DELAY_LONG 12'd1024
`define ATD_TRIM_CYCLES 8'd64
`define ATD_SAMPLE_DIV 3'd7
`define ATD_CMD_PHASE 5'd16
`define ATD_FLUSH_PAIRS 3'd4

// ==========================================================
// Receiver register byte offsets
`define ATD_REG_CTRL 5'h00
`define ATD_REG_STATUS 5'h04
`define ATD_REG_DATA 5'h08
`define ATD_REG_IRQ_STAT 5'h0c
`define ATD_REG_IRQ_MASK 5'h10

// ==========================================================
// Control register bit positions
`define ATD_CTRL_TRIM 0
`define ATD_CTRL_SLEEP 1
`define ATD_CTRL_EDGE 2
`define ATD_CTRL_DELAY 3

// ==========================================================
// Interrupt status bit positions
`define ATD_IRQ_TRIM_DONE 0
`define ATD_IRQ_RANGE 1
`define ATD_IRQ_PAIR 2

`endif

/* File: shared/atd_pkg.sv */
// Types shared by both ends of the converter link.
package atd_pkg;

  typedef logic [7:0] atd_code_t;

  typedef enum logic [2:0] {
    ATD_ST_BOOT = 3'b000,
    ATD_ST_POR_WAIT = 3'b001,
    ATD_ST_TRIM = 3'b010,
    ATD_ST_IDLE = 3'b011,
    ATD_ST_SLEEP = 3'b100
  } atd_state_e;

  typedef enum logic [1:0] {
    ATD_CMD_IDLE = 2'b00,
    ATD_CMD_LOW = 2'b01,
    ATD_CMD_HIGH = 2'b10
  } atd_cmd_e;

endpackage

/* File: shared/atd_link_if.sv */
// Link between the converter end and the receiving capture logic.
`timescale 1ns/1ns
interface atd_link_if;
  import atd_pkg::*;

  // Control pins driven by the receiver.
  logic selftrim_request;
  logic low_power_request;
  logic launch_edge_select;
  logic selftrim_delay_select;
  // Output pins driven by the converter; pins_oe high while they are driven.
  atd_code_t bus_a;
  atd_code_t bus_b;
  logic output_strobe;
  logic out_of_range;
  logic pins_oe;
  logic selftrim_active;

  modport dev (
    input selftrim_request,
    input low_power_request,
    input launch_edge_select,
    input selftrim_delay_select,
    output bus_a,
    output bus_b,
    output output_strobe,
    output out_of_range,
    output pins_oe,
    output selftrim_active
  );

  modport rcv (
    output selftrim_request,
    output low_power_request,
    output launch_edge_select,
    output selftrim_delay_select,
    input bus_a,
    input bus_b,
    input output_strobe,
    input out_of_range,
    input pins_oe,
    input selftrim_active
  );
endinterface

/* File: hw/atd_receiver.sv */
// Receiving end: drives the control pins, captures both buses, and serves Avalon-MM registers.
`timescale 1ns/1ns
`include "atd_defs.svh"

module atd_receiver
  import atd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Link to the converter
  atd_link_if.rcv link
);

  // ==========================================================
  // Avalon-MM slave

  logic wait_q;
  logic [31:0] rdata_q;
  logic [2:0] ctrl_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic irq_q;
  logic [15:0] pair_q;
  logic cmd_busy;
  logic flushing;
  logic [19:0] f_q;
  wire logic take = !wait_q && (avs_read || avs_write);
  wire logic wr = take && avs_write;
  wire logic wr_ctrl = wr && (avs_address == `ATD_REG_CTRL);
  wire logic wr_stat = wr && (avs_address == `ATD_REG_IRQ_STAT);
  wire logic wr_mask = wr && (avs_address == `ATD_REG_IRQ_MASK);
  wire logic start_cmd = wr_ctrl && avs_writedata[`ATD_CTRL_TRIM];
  wire logic [31:0] rd_mux =
    (avs_address == `ATD_REG_CTRL) ? {28'h0, ctrl_q, 1'b0} :
    (avs_address == `ATD_REG_STATUS) ? {28'h0, flushing, f_q[19], f_q[17], cmd_busy} :
    (avs_address == `ATD_REG_DATA) ? {16'h0, pair_q} :
    (avs_address == `ATD_REG_IRQ_STAT) ? {29'h0, stat_q} :
    (avs_address == `ATD_REG_IRQ_MASK) ? {29'h0, mask_q} : 32'h0;

  // Every request is answered one cycle after it appears.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= !(wait_q && (avs_read || avs_write));
      if (wait_q && avs_read) rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= avs_writedata[`ATD_CTRL_DELAY:`ATD_CTRL_SLEEP];
      if (wr_mask) mask_q <= avs_writedata[2:0];
    end
  end

  // ==========================================================
  // Trim request sequencer

  atd_cmd_e cmd_q;
  logic [4:0] cmd_cnt_q;
  logic req_q;
  wire logic phase_end = (cmd_cnt_q == `ATD_CMD_PHASE - 5'd1);
  assign cmd_busy = (cmd_q != ATD_CMD_IDLE);

  // Each phase lasts longer than the qualifying run plus synchroniser slack.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= ATD_CMD_IDLE;
      cmd_cnt_q <= 5'h0;
      req_q <= 1'b0;
    end else begin
      cmd_cnt_q <= (cmd_busy && !phase_end) ? cmd_cnt_q + 5'h1 : 5'h0;
      case (cmd_q)
        ATD_CMD_IDLE: if (start_cmd) cmd_q <= ATD_CMD_LOW;
        ATD_CMD_LOW: if (phase_end) cmd_q <= ATD_CMD_HIGH;
        ATD_CMD_HIGH: if (phase_end) cmd_q <= ATD_CMD_IDLE;
        default: cmd_q <= ATD_CMD_IDLE;
      endcase
      req_q <= (cmd_q == ATD_CMD_LOW && phase_end) || (cmd_q == ATD_CMD_HIGH && !phase_end);
    end
  end

  // ==========================================================
  // Capture of both buses

  logic [19:0] s1_q;
  logic [19:0] s2_q;
  logic [19:0] s3_q;
  logic strobe_prev_q;
  logic oe_prev_q;
  logic act_prev_q;
  logic [2:0] flush_q;
  wire logic [19:0] pins = {link.pins_oe, link.output_strobe, link.selftrim_active,
                            link.out_of_range, link.bus_b, link.bus_a};
  wire logic edge_sel = ctrl_q[`ATD_CTRL_EDGE - 1];
  wire logic strobe_rise = f_q[18] && !strobe_prev_q;
  wire logic strobe_fall = !f_q[18] && strobe_prev_q;
  wire logic capture = f_q[19] && (edge_sel ? strobe_fall : strobe_rise);
  wire logic deliver = capture && (flush_q == 3'h0) && oe_prev_q;
  assign flushing = (flush_q != 3'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 20'h0;
      s2_q <= 20'h0;
      s3_q <= 20'h0;
      f_q <= 20'h0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  // Pairs launched before the pins came back are stale and are dropped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_prev_q <= 1'b0;
      oe_prev_q <= 1'b0;
      act_prev_q <= 1'b0;
      flush_q <= `ATD_FLUSH_PAIRS;
      pair_q <= 16'h0;
    end else begin
      strobe_prev_q <= f_q[18];
      oe_prev_q <= f_q[19];
      act_prev_q <= f_q[17];
      if (f_q[19] && !oe_prev_q) begin
        flush_q <= `ATD_FLUSH_PAIRS;
      end else if (capture && flushing) begin
        flush_q <= flush_q - 3'h1;
      end
      if (deliver) pair_q <= f_q[15:0];
    end
  end

  // ==========================================================
  // Interrupts

  wire logic [2:0] ev = {deliver, deliver && f_q[16], act_prev_q && !f_q[17]};
  wire logic [2:0] clr = wr_stat ? avs_writedata[2:0] : 3'h0;
  wire logic [2:0] stat_d = (stat_q & ~clr) | ev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign irq = irq_q;
  assign link.selftrim_request = req_q;
  assign link.low_power_request = ctrl_q[`ATD_CTRL_SLEEP - 1];
  assign link.launch_edge_select = ctrl_q[`ATD_CTRL_EDGE - 1];
  assign link.selftrim_delay_select = ctrl_q[`ATD_CTRL_DELAY - 1];

endmodule // atd_receiver

/* File: testbench/atd_link_monitor.sv */
// Concurrent checks on the link between the converter end and the receiver.
`timescale 1ns/1ns
module atd_link_monitor
  import atd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control pins
  input wire logic selftrim_request,
  input wire logic low_power_request,
  input wire logic launch_edge_select,
  input wire logic selftrim_delay_select,
  // Converter outputs
  input wire atd_code_t bus_a,
  input wire atd_code_t bus_b,
  input wire logic output_strobe,
  input wire logic out_of_range,
  input wire logic pins_oe,
  input wire logic selftrim_active
);
  // ==========================================================
  // Length of the current trim, in cycles.
  logic [7:0] trim_cnt_q;
  logic [7:0] trim_cnt_d;
  assign trim_cnt_d = selftrim_active ? trim_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_cnt_q <= 8'h00;
    end else begin
      trim_cnt_q <= trim_cnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Assertions
  trim_length_a: assert property ($fell(selftrim_active) |-> trim_cnt_q == 8'h40)
    else $error("trim did not last 64 cycles");
  trim_bound_a: assert property (selftrim_active |-> trim_cnt_q < 8'h40)
    else $error("trim ran past 64 cycles");
  sleep_release_a: assert property ((low_power_request && !selftrim_active)[*8] |-> !pins_oe)
    else $error("pins driven in low power");
  strobe_period_a: assert property ($changed(output_strobe) && pins_oe
      |=> ($stable(output_strobe) || !pins_oe)[*7])
    else $error("strobe toggled early");
  launch_edge_a: assert property ($changed(bus_a) && pins_oe && $past(pins_oe)
      && $past(launch_edge_select, 16) == launch_edge_select
      |-> $changed(output_strobe) && output_strobe == launch_edge_select)
    else $error("data changed on wrong strobe edge");
  pair_stand_a: assert property ($changed(bus_b) && pins_oe
      |=> ($stable(bus_b) || !pins_oe)[*8])
    else $error("bus data did not stand");
  range_code_a: assert property (out_of_range && pins_oe
      |-> (bus_a == 8'h00 || bus_a == 8'hff || bus_b == 8'h00 || bus_b == 8'hff))
    else $error("range flag without clipped code");
  range_timing_a: assert property ($changed(out_of_range) && pins_oe && $past(pins_oe)
      |-> $changed(output_strobe))
    else $error("range flag moved off a strobe edge");
  sleep_no_trim_a: assert property ($rose(selftrim_active)
      |-> !$past(low_power_request, 8))
    else $error("trim began from low power");

  cover property ($rose(selftrim_active) && !selftrim_request);
  cover property ($fell(selftrim_active) && low_power_request);
  cover property (out_of_range && pins_oe && !selftrim_delay_select);
  cover property ($changed(launch_edge_select));
endmodule // atd_link_monitor

/* File: testbench/tb_adc_trim_powerdown_output_demux.sv */
// Self-checking bench joining the converter end and the receiver over the link.
`timescale 1ns/1ns
`include "atd_defs.svh"
module tb_adc_trim_powerdown_output_demux;
  import atd_pkg::*;
  logic clk;
  logic rst_n;
  logic dev_rst_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [9:0] conv_value;
  logic ramp_on;
  logic [31:0] rd;
  int failures;
  int compares;
  int cyc;
  int t0;
  int i;
  logic [9:0] vals [7] = '{10'h000, 10'h3ff, 10'h07f, 10'h080, 10'h380, 10'h338, 10'h005};
  atd_code_t codes [7] = '{8'h80, 8'h7f, 8'hff, 8'hff, 8'h00, 8'h00, 8'h85};
  logic [6:0] oor_m = 7'h28;

  atd_link_if link();
  atd_device atd_device_inst (.clk(clk), .rst_n(dev_rst_n), .conv_value(conv_value),
    .core_sleep(), .core_trim(), .link(link));
  atd_receiver atd_receiver_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .link(link));
  atd_link_monitor atd_link_monitor_inst (.clk(clk), .rst_n(dev_rst_n),
    .selftrim_request(link.selftrim_request), .low_power_request(link.low_power_request),
    .launch_edge_select(link.launch_edge_select),
    .selftrim_delay_select(link.selftrim_delay_select), .bus_a(link.bus_a),
    .bus_b(link.bus_b), .output_strobe(link.output_strobe), .out_of_range(link.out_of_range),
    .pins_oe(link.pins_oe), .selftrim_active(link.selftrim_active));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Free cycle count, and a ramp that steps once per conversion.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ramp_on && (cyc % 8) == 0) begin
      conv_value <= conv_value + 10'h001;
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic [4:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      failures++;
      $display("mismatch waitrequest expected 0 seen 1");
      wrap_up();
    end
  endtask

  task automatic wait_stat(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      xfer(`ATD_REG_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[b] !== v && n < lim);
    if (rd[b] !== v) begin
      failures++;
      $display("mismatch status bit %0d expected %b seen %b", b, v, rd[b]);
      wrap_up();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    dev_rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    conv_value = 10'h000;
    ramp_on = 1'b0;
    failures = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    t0 = cyc;
    wait_stat(1, 1'b1, 200);
    check("power-on delay", 32'h1, (cyc - t0) >= 256 && (cyc - t0) < 300);
    wait_stat(1, 1'b0, 60);
    xfer(5'h14, 1'b0, 32'h0);
    check("unmapped read", 32'h0, rd);
    xfer(`ATD_REG_IRQ_STAT, 1'b0, 32'h0);
    check("trim done flag", 32'h1, rd[`ATD_IRQ_TRIM_DONE]);
    xfer(`ATD_REG_IRQ_MASK, 1'b1, 32'h1);
    xfer(`ATD_REG_IRQ_STAT, 1'b1, 32'h7);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, irq);
    xfer(`ATD_REG_CTRL, 1'b1, 32'h1);
    t0 = cyc;
    wait_stat(1, 1'b1, 100);
    check("command start", 32'h1, (cyc - t0) >= 26 && (cyc - t0) <= 48);
    wait_stat(1, 1'b0, 60);
    repeat (4) @(posedge clk);
    check("irq raised", 32'h1, irq);
    xfer(`ATD_REG_IRQ_MASK, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    check("irq masked", 32'h0, irq);
    xfer(`ATD_REG_IRQ_STAT, 1'b1, 32'h7);
    // Power-down while trimming, then a command that must be ignored.
    xfer(`ATD_REG_CTRL, 1'b1, 32'h1);
    wait_stat(1, 1'b1, 100);
    xfer(`ATD_REG_CTRL, 1'b1, 32'h2);
    wait_stat(1, 1'b0, 60);
    repeat (20) @(posedge clk);
    xfer(`ATD_REG_STATUS, 1'b0, 32'h0);
    check("pins released", 32'h0, rd[2]);
    xfer(`ATD_REG_IRQ_STAT, 1'b1, 32'h7);
    xfer(`ATD_REG_CTRL, 1'b1, 32'h3);
    repeat (100) @(posedge clk);
    xfer(`ATD_REG_IRQ_STAT, 1'b0, 32'h0);
    check("trim in sleep", 32'h0, rd[`ATD_IRQ_TRIM_DONE]);
    xfer(`ATD_REG_CTRL, 1'b1, 32'h0);
    wait_stat(2, 1'b1, 50);
    xfer(`ATD_REG_STATUS, 1'b0, 32'h0);
    check("flushing", 32'h1, rd[3]);
    repeat (100) @(posedge clk);
    xfer(`ATD_REG_DATA, 1'b0, 32'h0);
    check("pair after wake", 32'h8080, rd[15:0]);
    for (i = 0; i < 7; i++) begin
      conv_value <= vals[i];
      repeat (80) @(posedge clk);
      xfer(`ATD_REG_DATA, 1'b0, 32'h0);
      check("pair code", {codes[i], codes[i]}, rd[15:0]);
      xfer(`ATD_REG_IRQ_STAT, 1'b1, 32'h2);
      repeat (40) @(posedge clk);
      xfer(`ATD_REG_IRQ_STAT, 1'b0, 32'h0);
      check("range flag", oor_m[i], rd[`ATD_IRQ_RANGE]);
    end
    for (i = 0; i < 2; i++) begin
      xfer(`ATD_REG_CTRL, 1'b1, (i == 1) ? 32'h4 : 32'h0);
      ramp_on <= 1'b1;
      repeat (100) @(posedge clk);
      xfer(`ATD_REG_DATA, 1'b0, 32'h0);
      check("pair order", rd[7:0] + 8'h01, rd[15:8]);
      ramp_on <= 1'b0;
    end
    xfer(`ATD_REG_IRQ_MASK, 1'b1, 32'h4);
    repeat (40) @(posedge clk);
    check("pair irq", 32'h1, irq);
    xfer(`ATD_REG_IRQ_MASK, 1'b1, 32'h0);
    // Power-up with power-down held and the long delay chosen.
    xfer(`ATD_REG_CTRL, 1'b1, 32'ha);
    repeat (20) @(posedge clk);
    dev_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    dev_rst_n <= 1'b1;
    repeat (1400) @(posedge clk);
    xfer(`ATD_REG_STATUS, 1'b0, 32'h0);
    check("held asleep", 32'h0, rd[2:1]);
    xfer(`ATD_REG_CTRL, 1'b1, 32'h8);
    t0 = cyc;
    wait_stat(1, 1'b1, 600);
    check("long delay", 32'h1, (cyc - t0) >= 1024 && (cyc - t0) < 1070);
    wait_stat(1, 1'b0, 60);
    wrap_up();
  end
endmodule // tb_adc_trim_powerdown_output_demux
